/* rtl/aord_regs.svh */
// Purpose: Register offsets, reset values and field positions of the over-range detector.
// Assumes: Byte-wide registers addressed by a 12-bit register address.
// Notes:   Definitions only.
`ifndef AORD_REGS_SVH
`define AORD_REGS_SVH

`define AORD_ADDR_GAIN_LO   12'h022
`define AORD_ADDR_GAIN_HI   12'h023
`define AORD_ADDR_OFS_LO    12'h025
`define AORD_ADDR_OFS_HI    12'h026
`define AORD_ADDR_THR_HI    12'h030
`define AORD_ADDR_THR_LO    12'h031
`define AORD_ADDR_WIN_EXP   12'h032
`define AORD_ADDR_CTRL      12'h033
`define AORD_ADDR_STATUS    12'h034

`define AORD_RST_BYTE       8'h00
`define AORD_RST_THR_HI     8'he4
`define AORD_RST_THR_LO     8'h40
`define AORD_RST_EXP        3'h0
`define AORD_RST_CNT        7'h00
`define AORD_RST_WORD       16'h0000
`define AORD_RST_FLAGS      2'h0

`define AORD_CTRL_BGCAL     0
`define AORD_STAT_IFLAG     0
`define AORD_STAT_QFLAG     1
`define AORD_EXP_MSB        2

`define AORD_CMP_MSB        10
`define AORD_CMP_LSB        3
`define AORD_MAG_MAX        11'h7ff
`define AORD_TC_MIN         12'h800
`define AORD_CNT_ONE        7'h01
`define AORD_CNT_MAX        7'h7f
`define AORD_EXP_MIN        3'h0
`define AORD_EXP_MAX        3'h7

`endif

/* rtl/aord_pkg.sv */
// Purpose: Types shared by the over-range detector files.
// Assumes: Fifteen-bit complex samples arrive from the down-converter.
// Notes:   Constants live in aord_regs.svh.
package aord_pkg;

  typedef struct packed {
    logic [14:0] i;
    logic [14:0] q;
  } aord_ddc_type;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } aord_cplx_type;

endpackage : aord_pkg

/* rtl/aord_mag.sv */
// Purpose: Magnitude of one raw converter sample and its two threshold hits.
// Assumes: Raw samples are offset binary, 12 bits.
// Notes:   Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`include "aord_regs.svh"
`default_nettype none

module aord_mag (
  input  wire logic [11:0] sample_in,
  input  wire logic [7:0]  thr_hi_in,
  input  wire logic [7:0]  thr_lo_in,
  output logic      [10:0] mag_out,
  output logic      [1:0]  hit_out
);

  logic [11:0] tc;
  logic [11:0] neg;
  logic [7:0]  thr [2];

  assign thr[0] = thr_hi_in;
  assign thr[1] = thr_lo_in;

  // Flip the sign bit to go from offset binary to two's complement.
  assign tc  = {~sample_in[11], sample_in[10:0]};
  assign neg = 12'h000 - tc;

  // The most negative code has no positive twin, so it saturates to full scale.
  always_comb begin
    if (tc == `AORD_TC_MIN) begin
      mag_out = `AORD_MAG_MAX;
    end else if (tc[11]) begin
      mag_out = neg[10:0];
    end else begin
      mag_out = tc[10:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cmp
      assign hit_out[g] = (mag_out[`AORD_CMP_MSB:`AORD_CMP_LSB] >= thr[g]);
    end
  endgenerate

endmodule : aord_mag

`default_nettype wire

/* rtl/aord_skid.sv */
// Purpose: Two-entry buffer in the complex sample path.
// Assumes: Source and sink share clk_in.
// Notes:   Ready toward the source is registered, so a second entry absorbs the stall.
`timescale 1ns/1ps
`include "aord_regs.svh"
`default_nettype none

module aord_skid (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  input  wire aord_pkg::aord_cplx_type in_data_in,
  input  wire logic                   in_valid_in,
  output logic                        in_ready_out,
  output aord_pkg::aord_cplx_type     out_data_out,
  output logic                        out_valid_out,
  input  wire logic                   out_ready_in
);

  aord_pkg::aord_cplx_type main_d_r, main_d_nxt, skid_d_r, skid_d_nxt;
  logic                    main_v_r, main_v_nxt, skid_v_r, skid_v_nxt;
  logic                    rdy_r, rdy_nxt;
  logic                    push, pop;

  assign push = in_valid_in & rdy_r;
  assign pop  = main_v_r & out_ready_in;

  always_comb begin
    main_v_nxt = main_v_r;
    main_d_nxt = main_d_r;
    skid_v_nxt = skid_v_r;
    skid_d_nxt = skid_d_r;
    if (!main_v_r || pop) begin
      if (skid_v_r) begin
        main_v_nxt = 1'b1;
        main_d_nxt = skid_d_r;
        skid_v_nxt = 1'b0;
      end else begin
        main_v_nxt = push;
        if (push) begin
          main_d_nxt = in_data_in;
        end
      end
    end else if (push) begin
      skid_v_nxt = 1'b1;
      skid_d_nxt = in_data_in;
    end
    rdy_nxt = ~skid_v_nxt;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      main_v_r <= 1'b0;
      skid_v_r <= 1'b0;
      rdy_r    <= 1'b0;
      main_d_r <= '0;
      skid_d_r <= '0;
    end else if (ce_in) begin
      main_v_r <= main_v_nxt;
      skid_v_r <= skid_v_nxt;
      rdy_r    <= rdy_nxt;
      main_d_r <= main_d_nxt;
      skid_d_r <= skid_d_nxt;
    end
  end

  assign in_ready_out  = rdy_r;
  assign out_valid_out = main_v_r;
  assign out_data_out  = main_d_r;

endmodule : aord_skid

`default_nettype wire

/* rtl/aord_top.sv */
// Purpose: Over-range detector with embedded flags, gain and offset trim registers.
// Assumes: One clock, synchronous active-high reset, sources on the same clock.
// Notes:   Rules below are tagged at the logic that carries them out.
// Functional notes
// - Compare the upper eight magnitude bits of every raw sample with both thresholds.
// - Offset binary to two's complement to magnitude; most negative saturates to 2047.
// - Flag is one if any sample in the window reaches its threshold.
// - Window length is two to the power of the exponent, 1 to 128.
// - In-phase samples carry the high-threshold flag as their lowest bit.
// - Quadrature samples carry the low-threshold flag as their lowest bit.
// - Full-scale gain setting spans two registers and drives the range adjust.
// - Input offset setting spans two registers and drives the offset correction.
// - Offset correction is ignored while background calibration is active.
`timescale 1ns/1ps
`include "aord_regs.svh"
`default_nettype none

module aord_top (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  input  wire logic [11:0]            raw_sample_in,
  input  wire logic                   raw_valid_in,
  input  wire aord_pkg::aord_ddc_type  ddc_data_in,
  input  wire logic                   ddc_valid_in,
  output logic                        ddc_ready_out,
  output aord_pkg::aord_cplx_type     cplx_data_out,
  output logic                        cplx_valid_out,
  input  wire logic                   cplx_ready_in,
  input  wire logic [11:0]            reg_addr_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  input  wire logic [7:0]             reg_wdata_in,
  output logic      [7:0]             reg_rdata_out,
  output logic                        reg_rvalid_out,
  output logic      [15:0]            full_scale_gain_setting_out,
  output logic      [15:0]            input_offset_setting_out,
  output logic                        inphase_overrange_flag_out,
  output logic                        quadrature_overrange_flag_out
);

  // Configuration registers.
  logic [7:0]  gain_lo_r, gain_lo_nxt, gain_hi_r, gain_hi_nxt;
  logic [7:0]  ofs_lo_r, ofs_lo_nxt, ofs_hi_r, ofs_hi_nxt;
  logic [7:0]  thr_hi_r, thr_hi_nxt, thr_lo_r, thr_lo_nxt;
  logic [2:0]  exp_r, exp_nxt;
  logic        bgcal_r, bgcal_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [15:0] ofs_out_r, ofs_out_nxt;

  // Window state.
  logic [6:0]  cnt_r, cnt_nxt;
  logic [1:0]  acc_r, acc_nxt;
  logic [1:0]  flag_r, flag_nxt;

  logic [10:0] mag;
  logic [1:0]  hit;
  logic [1:0]  hit_any;
  logic [6:0]  win_last;
  logic        win_end;

  aord_pkg::aord_cplx_type emb;

  aord_mag u_mag (
    .sample_in (raw_sample_in),
    .thr_hi_in (thr_hi_r),
    .thr_lo_in (thr_lo_r),
    .mag_out   (mag),
    .hit_out   (hit)
  );

  // Exponent 7 wraps the shifted one to zero, so the subtraction yields 127.
  assign win_last = (`AORD_CNT_ONE << exp_r) - `AORD_CNT_ONE;
  assign hit_any  = acc_r | hit;
  // Testing for at or past the end keeps a shortened window from running 128 long.
  assign win_end  = raw_valid_in & (cnt_r >= win_last);

  // Register access.
  always_comb begin
    gain_lo_nxt = gain_lo_r;
    gain_hi_nxt = gain_hi_r;
    ofs_lo_nxt  = ofs_lo_r;
    ofs_hi_nxt  = ofs_hi_r;
    thr_hi_nxt  = thr_hi_r;
    thr_lo_nxt  = thr_lo_r;
    exp_nxt     = exp_r;
    bgcal_nxt   = bgcal_r;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `AORD_ADDR_GAIN_LO: gain_lo_nxt = reg_wdata_in;
        `AORD_ADDR_GAIN_HI: gain_hi_nxt = reg_wdata_in;
        `AORD_ADDR_OFS_LO:  ofs_lo_nxt  = reg_wdata_in;
        `AORD_ADDR_OFS_HI:  ofs_hi_nxt  = reg_wdata_in;
        `AORD_ADDR_THR_HI:  thr_hi_nxt  = reg_wdata_in;
        `AORD_ADDR_THR_LO:  thr_lo_nxt  = reg_wdata_in;
        `AORD_ADDR_WIN_EXP: exp_nxt     = reg_wdata_in[`AORD_EXP_MSB:0];
        `AORD_ADDR_CTRL:    bgcal_nxt   = reg_wdata_in[`AORD_CTRL_BGCAL];
        default: begin
        end
      endcase
    end
    rvalid_nxt = reg_rd_in;
    rdata_nxt  = `AORD_RST_BYTE;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `AORD_ADDR_GAIN_LO: rdata_nxt = gain_lo_r;
        `AORD_ADDR_GAIN_HI: rdata_nxt = gain_hi_r;
        `AORD_ADDR_OFS_LO:  rdata_nxt = ofs_lo_r;
        `AORD_ADDR_OFS_HI:  rdata_nxt = ofs_hi_r;
        `AORD_ADDR_THR_HI:  rdata_nxt = thr_hi_r;
        `AORD_ADDR_THR_LO:  rdata_nxt = thr_lo_r;
        `AORD_ADDR_WIN_EXP: rdata_nxt = {5'h00, exp_r};
        `AORD_ADDR_CTRL:    rdata_nxt = {7'h00, bgcal_r};
        `AORD_ADDR_STATUS:  rdata_nxt = {6'h00, flag_r};
        default:            rdata_nxt = `AORD_RST_BYTE;
      endcase
    end
    // Background calibration owns the offset, so the trim is held off the analog side.
    ofs_out_nxt = bgcal_r ? `AORD_RST_WORD : {ofs_hi_r, ofs_lo_r};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gain_lo_r <= `AORD_RST_BYTE;
      gain_hi_r <= `AORD_RST_BYTE;
      ofs_lo_r  <= `AORD_RST_BYTE;
      ofs_hi_r  <= `AORD_RST_BYTE;
      thr_hi_r  <= `AORD_RST_THR_HI;
      thr_lo_r  <= `AORD_RST_THR_LO;
      exp_r     <= `AORD_RST_EXP;
      bgcal_r   <= 1'b0;
      rdata_r   <= `AORD_RST_BYTE;
      rvalid_r  <= 1'b0;
      ofs_out_r <= `AORD_RST_WORD;
    end else if (ce_in) begin
      gain_lo_r <= gain_lo_nxt;
      gain_hi_r <= gain_hi_nxt;
      ofs_lo_r  <= ofs_lo_nxt;
      ofs_hi_r  <= ofs_hi_nxt;
      thr_hi_r  <= thr_hi_nxt;
      thr_lo_r  <= thr_lo_nxt;
      exp_r     <= exp_nxt;
      bgcal_r   <= bgcal_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
      ofs_out_r <= ofs_out_nxt;
    end
  end

  // Monitoring window.
  always_comb begin
    cnt_nxt  = cnt_r;
    acc_nxt  = acc_r;
    flag_nxt = flag_r;
    if (win_end) begin
      flag_nxt = hit_any;
      acc_nxt  = `AORD_RST_FLAGS;
      cnt_nxt  = `AORD_RST_CNT;
    end else if (raw_valid_in) begin
      acc_nxt  = hit_any;
      cnt_nxt  = cnt_r + `AORD_CNT_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r  <= `AORD_RST_CNT;
      acc_r  <= `AORD_RST_FLAGS;
      flag_r <= `AORD_RST_FLAGS;
    end else if (ce_in) begin
      cnt_r  <= cnt_nxt;
      acc_r  <= acc_nxt;
      flag_r <= flag_nxt;
    end
  end

  // Flags ride in the lowest bit under the fifteen data bits of each sample.
  assign emb.i = {ddc_data_in.i, flag_r[`AORD_STAT_IFLAG]};
  assign emb.q = {ddc_data_in.q, flag_r[`AORD_STAT_QFLAG]};

  aord_skid u_skid (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .in_data_in    (emb),
    .in_valid_in   (ddc_valid_in),
    .in_ready_out  (ddc_ready_out),
    .out_data_out  (cplx_data_out),
    .out_valid_out (cplx_valid_out),
    .out_ready_in  (cplx_ready_in)
  );

  assign reg_rdata_out                 = rdata_r;
  assign reg_rvalid_out                = rvalid_r;
  assign full_scale_gain_setting_out   = {gain_hi_r, gain_lo_r};
  assign input_offset_setting_out      = ofs_out_r;
  assign inphase_overrange_flag_out    = flag_r[`AORD_STAT_IFLAG];
  assign quadrature_overrange_flag_out = flag_r[`AORD_STAT_QFLAG];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_cmp_upper_bits: assert property (
    hit[0] == (mag[`AORD_CMP_MSB:`AORD_CMP_LSB] >= thr_hi_r) &&
    hit[1] == (mag[`AORD_CMP_MSB:`AORD_CMP_LSB] >= thr_lo_r))
    else $error("Threshold hit does not follow the upper magnitude bits.");

  a_mag_conversion: assert property (
    (raw_sample_in == 12'h000 |-> mag == 11'h7ff) and
    (raw_sample_in == 12'h010 |-> mag == 11'h7f0) and
    (raw_sample_in == 12'hff0 |-> mag == 11'h7f0) and
    (raw_sample_in == 12'h800 |-> mag == 11'h000))
    else $error("Sample magnitude is wrong.");

  a_flag_window_result: assert property (
    ce_in && win_end |=> flag_r == $past(acc_r | hit))
    else $error("Window result does not match the samples seen.");

  a_window_count_step: assert property (
    ce_in && raw_valid_in && !win_end |=>
      cnt_r == $past(cnt_r) + `AORD_CNT_ONE && cnt_r <= $past(win_last))
    else $error("Window counter did not step within its length.");

  a_embed_inphase: assert property (
    ce_in && ddc_valid_in && ddc_ready_out && !cplx_valid_out |=>
      cplx_valid_out &&
      cplx_data_out.i == {$past(ddc_data_in.i), $past(flag_r[`AORD_STAT_IFLAG])})
    else $error("In-phase sample lost its high-threshold flag.");

  a_embed_quad: assert property (
    ce_in && ddc_valid_in && ddc_ready_out && !cplx_valid_out |=>
      cplx_valid_out &&
      cplx_data_out.q == {$past(ddc_data_in.q), $past(flag_r[`AORD_STAT_QFLAG])})
    else $error("Quadrature sample lost its low-threshold flag.");

  a_gain_write: assert property (
    ce_in && reg_wr_in && reg_addr_in == `AORD_ADDR_GAIN_HI |=>
      full_scale_gain_setting_out[15:8] == $past(reg_wdata_in))
    else $error("Gain setting did not take the written byte.");

  a_offset_applied: assert property (
    ce_in && !bgcal_r |=> input_offset_setting_out == $past({ofs_hi_r, ofs_lo_r}))
    else $error("Offset setting not passed to the correction.");

  a_offset_bgcal: assert property (
    ce_in && bgcal_r |=> input_offset_setting_out == `AORD_RST_WORD)
    else $error("Offset correction active during background calibration.");

  a_flag_hold: assert property (
    !(ce_in && win_end) |=> $stable(flag_r))
    else $error("Flags changed before the window closed.");

  // Checks below watch only what the block drives; the inputs are the bench's business.
  a_gain_low_write: assert property (
    ce_in && reg_wr_in && reg_addr_in == `AORD_ADDR_GAIN_LO |=>
      full_scale_gain_setting_out[7:0] == $past(reg_wdata_in))
    else $error("Gain low byte did not take the written byte.");

  a_gain_readback: assert property (
    ce_in && reg_rd_in && reg_addr_in == `AORD_ADDR_GAIN_HI |=>
      reg_rvalid_out && reg_rdata_out == $past(full_scale_gain_setting_out[15:8]))
    else $error("Gain high byte read back wrong.");

  a_read_pulse: assert property (
    ce_in && !reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == `AORD_RST_BYTE)
    else $error("Read answer shown without a read.");

  a_offset_low_write: assert property (
    ce_in && reg_wr_in && reg_addr_in == `AORD_ADDR_OFS_LO ##1 ce_in && !bgcal_r |=>
      input_offset_setting_out[7:0] == $past(reg_wdata_in, 2))
    else $error("Offset low byte did not reach the correction.");

  a_offset_high_write: assert property (
    ce_in && reg_wr_in && reg_addr_in == `AORD_ADDR_OFS_HI ##1 ce_in && !bgcal_r |=>
      input_offset_setting_out[15:8] == $past(reg_wdata_in, 2))
    else $error("Offset high byte did not reach the correction.");

  a_status_read: assert property (
    ce_in && reg_rd_in && reg_addr_in == `AORD_ADDR_STATUS |=>
      reg_rvalid_out && reg_rdata_out == {6'h00, $past(flag_r)})
    else $error("Status read does not show the held flags.");

  a_hit_accumulate: assert property (
    ce_in && raw_valid_in && !win_end |=> acc_r == $past(acc_r | hit))
    else $error("Threshold hit lost inside the window.");

  a_window_of_one: assert property (
    raw_valid_in && exp_r == `AORD_EXP_MIN |-> win_end)
    else $error("Window of one sample did not close.");

  a_window_max_len: assert property (
    exp_r == `AORD_EXP_MAX |-> win_last == `AORD_CNT_MAX)
    else $error("Longest window is not 128 samples.");

  a_idle_not_counted: assert property (
    ce_in && !raw_valid_in |=> $stable(cnt_r) && $stable(acc_r))
    else $error("A cycle without a sample moved the window.");

  a_window_restart: assert property (
    ce_in && win_end |=> cnt_r == `AORD_RST_CNT && acc_r == `AORD_RST_FLAGS)
    else $error("Next window did not start clean.");

  a_stall_word_hold: assert property (
    ce_in && cplx_valid_out && !cplx_ready_in |=> cplx_valid_out && $stable(cplx_data_out))
    else $error("Stalled output word changed.");

  a_freeze_state: assert property (
    !ce_in |=> $stable(flag_r) && $stable(cnt_r) && $stable(cplx_data_out))
    else $error("State moved while the clock enable was low.");

endmodule : aord_top

`default_nettype wire

/* tb/aord_sink_model.sv */
// Purpose: Downstream logic that takes the complex samples and steers system gain.
// Assumes: Same clock as the detector; I flag in bit 16, Q flag in bit 0.
// Notes:   Mode 1 is ready one cycle in four, mode 2 never ready, others always ready.
`timescale 1ns/1ps
`default_nettype none
module aord_sink_model (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic [1:0]              mode_in,
  input  wire aord_pkg::aord_cplx_type cplx_data_in,
  input  wire logic                    cplx_valid_in,
  output logic                         cplx_ready_out,
  output logic signed [7:0]            gain_step_out
);
  int seed = 46;
  int quiet;
  always @(posedge clk_in) begin
    if (rst_in) begin
      cplx_ready_out <= 1'b0;
      gain_step_out  <= 8'sh00;
      quiet = 0;
    end else begin
      cplx_ready_out <= (mode_in == 2'd1) ? (($random(seed) & 3) == 0) : (mode_in != 2'd2);
      gain_step_out  <= 8'sh00;
      if (cplx_valid_in && cplx_ready_out) begin
        quiet = cplx_data_in.q[0] ? 0 : quiet + 1;
        if (cplx_data_in.i[0]) begin
          gain_step_out <= -8'sh01;
        end else if (quiet >= 64) begin
          gain_step_out <= 8'sh01;
          quiet = 0;
        end
      end
    end
  end
endmodule : aord_sink_model
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench of the over-range detector against a behavioural model.
// Assumes: Inputs change 1 ns after the rising edge; the model mirrors every register.
// Notes:   Clock enable is randomised in the window sweep, so freezing is exercised too.
`timescale 1ns/1ps
`default_nettype none
`include "aord_regs.svh"
module tb;
  logic clk_in, rst_in, ce_in, raw_valid_in, ddc_valid_in, ddc_ready_out;
  logic cplx_valid_out, cplx_ready_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic inphase_overrange_flag_out, quadrature_overrange_flag_out;
  logic [11:0] raw_sample_in, reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, m_thh, m_thl, m_rd;
  logic [15:0] full_scale_gain_setting_out, input_offset_setting_out, m_gain, m_ofs, m_oout;
  logic [2:0] m_exp;
  logic [12:0] fix;
  logic [1:0] mode;
  logic m_cal, m_fi, m_fq, m_ah, m_al, m_rv, live, ce_rand;
  aord_pkg::aord_ddc_type ddc_data_in;
  aord_pkg::aord_cplx_type cplx_data_out;
  aord_pkg::aord_cplx_type q[$];
  int seed = 46;
  int bad_count = 0;
  int samples_checked = 0;
  int cnt, e, i;
  logic [11:0] alist[11] = '{12'h022, 12'h023, 12'h025, 12'h026, 12'h030, 12'h031,
                             12'h032, 12'h033, 12'h034, 12'h024, 12'h035};
  logic [11:0] blist[5] = '{12'hfff, 12'hff0, 12'h800, 12'h010, 12'h000};

  aord_top i_dut (.clk_in, .rst_in, .ce_in, .raw_sample_in, .raw_valid_in, .ddc_data_in,
    .ddc_valid_in, .ddc_ready_out, .cplx_data_out, .cplx_valid_out, .cplx_ready_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
    .full_scale_gain_setting_out, .input_offset_setting_out, .inphase_overrange_flag_out,
    .quadrature_overrange_flag_out);
  aord_sink_model i_sink (.clk_in, .rst_in, .mode_in(mode), .cplx_data_in(cplx_data_out),
    .cplx_valid_in(cplx_valid_out), .cplx_ready_out(cplx_ready_in), .gain_step_out());

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic cmp_val(input string n, input logic [15:0] x, input logic [15:0] g);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, x, g);
    end
  endtask : cmp_val

  task automatic cmp_word(input aord_pkg::aord_cplx_type x, input aord_pkg::aord_cplx_type g);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected output word: expected %h, seen %h", x, g);
    end
  endtask : cmp_word

  task automatic results;
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  function automatic logic [7:0] top8(input logic [11:0] s);
    int v;
    v = int'(s) - 2048;
    if (v < 0) v = (v == -2048) ? 2047 : -v;
    return v[10:3];
  endfunction : top8

  function automatic logic [7:0] rmod(input logic [11:0] a);
    case (a)
      `AORD_ADDR_GAIN_LO: return m_gain[7:0];
      `AORD_ADDR_GAIN_HI: return m_gain[15:8];
      `AORD_ADDR_OFS_LO:  return m_ofs[7:0];
      `AORD_ADDR_OFS_HI:  return m_ofs[15:8];
      `AORD_ADDR_THR_HI:  return m_thh;
      `AORD_ADDR_THR_LO:  return m_thl;
      `AORD_ADDR_WIN_EXP: return {5'h00, m_exp};
      `AORD_ADDR_CTRL:    return {7'h00, m_cal};
      `AORD_ADDR_STATUS:  return {6'h00, m_fq, m_fi};
      default:            return 8'h00;
    endcase
  endfunction : rmod

  // The model samples inputs in the active region of the edge, before the design's flops move.
  always @(posedge clk_in) begin : model
    logic hh, hl;
    hh = (top8(raw_sample_in) >= m_thh) | m_ah;
    hl = (top8(raw_sample_in) >= m_thl) | m_al;
    if (rst_in) begin
      {m_gain, m_ofs, m_oout} <= '0;
      {m_exp, m_cal, m_fi, m_fq, m_ah, m_al, m_rv, m_rd} <= '0;
      m_thh <= 8'he4;
      m_thl <= 8'h40;
      cnt = 0;
      q.delete();
    end else if (ce_in) begin
      m_rv <= reg_rd_in;
      m_rd <= reg_rd_in ? rmod(reg_addr_in) : 8'h00;
      m_oout <= m_cal ? 16'h0000 : m_ofs;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `AORD_ADDR_GAIN_LO: m_gain[7:0] <= reg_wdata_in;
          `AORD_ADDR_GAIN_HI: m_gain[15:8] <= reg_wdata_in;
          `AORD_ADDR_OFS_LO:  m_ofs[7:0] <= reg_wdata_in;
          `AORD_ADDR_OFS_HI:  m_ofs[15:8] <= reg_wdata_in;
          `AORD_ADDR_THR_HI:  m_thh <= reg_wdata_in;
          `AORD_ADDR_THR_LO:  m_thl <= reg_wdata_in;
          `AORD_ADDR_WIN_EXP: m_exp <= reg_wdata_in[2:0];
          `AORD_ADDR_CTRL:    m_cal <= reg_wdata_in[0];
          default: ;
        endcase
      end
      if (ddc_valid_in && ddc_ready_out)
        q.push_back(aord_pkg::aord_cplx_type'({ddc_data_in.i, m_fi, ddc_data_in.q, m_fq}));
      if (cplx_valid_out && cplx_ready_in)
        cmp_word(q.size() > 0 ? q.pop_front() : 'x, cplx_data_out);
      if (raw_valid_in) begin
        if (cnt >= (1 << m_exp) - 1) begin
          {m_fi, m_fq, m_ah, m_al} <= {hh, hl, 2'b00};
          cnt = 0;
        end else begin
          {m_ah, m_al} <= {hh, hl};
          cnt++;
        end
      end
    end
  end

  always @(negedge clk_in) begin
    if (live) begin
      cmp_val("inphase flag", m_fi, inphase_overrange_flag_out);
      cmp_val("quadrature flag", m_fq, quadrature_overrange_flag_out);
      cmp_val("read valid", m_rv, reg_rvalid_out);
      cmp_val("read data", m_rd, reg_rdata_out);
      cmp_val("gain setting", m_gain, full_scale_gain_setting_out);
      cmp_val("offset setting", m_oout, input_offset_setting_out);
    end
  end

  task automatic cyc(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
    logic took;
    int rv, rv2;
    // Judge the handshake from values that stand before the edge, not at the edge itself.
    took = ddc_valid_in & ddc_ready_out & ce_in;
    @(posedge clk_in);
    #1;
    rv = $random(seed);
    rv2 = $random(seed);
    // Writes keep the enable high so that every setting of the sweep really lands.
    ce_in = (ce_rand && !w) ? (rv[6:4] != 3'h0) : 1'b1;
    raw_valid_in = fix[12] | rv[1] | rv[2];
    raw_sample_in = fix[12] ? fix[11:0] : (rv[3] ? rv[19:8] : {8'h80, rv[11:8]});
    // The source holds a refused word until it is taken.
    if (took || !ddc_valid_in) begin
      ddc_data_in = aord_pkg::aord_ddc_type'(rv2[29:0]);
      ddc_valid_in = (mode == 2'd2) | ((mode != 2'd3) & rv[0]);
    end
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = {w, r, a, d};
  endtask : cyc

  initial begin
    {ce_in, raw_valid_in, ddc_valid_in, reg_wr_in, reg_rd_in, live, ce_rand} = '0;
    {raw_sample_in, reg_addr_in, reg_wdata_in, ddc_data_in, fix, mode} = '0;
    rst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    live = 1'b1;
    foreach (alist[k]) cyc(1'b0, 1'b1, alist[k], 8'h00);
    for (i = 0; i < 4; i++) cyc(1'b1, 1'b0, alist[i], 8'($random(seed)));
    cyc(1'b1, 1'b0, `AORD_ADDR_CTRL, 8'h01);
    repeat (4) cyc(1'b0, 1'b1, `AORD_ADDR_OFS_LO, 8'h00);
    cyc(1'b1, 1'b0, `AORD_ADDR_CTRL, 8'h00);
    foreach (alist[k]) cyc(1'b0, 1'b1, alist[k], 8'h00);
    cyc(1'b1, 1'b0, `AORD_ADDR_THR_HI, 8'hfe);
    cyc(1'b1, 1'b0, `AORD_ADDR_THR_LO, 8'hff);
    foreach (blist[k]) begin
      fix = {1'b1, blist[k]};
      cyc(1'b0, 1'b0, 12'h000, 8'h00);
    end
    fix = '0;
    ce_rand = 1'b1;
    for (e = 0; e < 8; e++) begin
      mode = 2'(e);
      cyc(1'b1, 1'b0, `AORD_ADDR_THR_HI, 8'($random(seed)));
      cyc(1'b1, 1'b0, `AORD_ADDR_THR_LO, 8'($random(seed)));
      cyc(1'b1, 1'b0, `AORD_ADDR_WIN_EXP, 8'(e));
      for (i = 0; i < (3 << e) + 6; i++) cyc(1'b0, i[0], `AORD_ADDR_STATUS, 8'h00);
    end
    ce_rand = 1'b0;
    mode = 2'd2;
    repeat (6) cyc(1'b0, 1'b0, 12'h000, 8'h00);
    cmp_val("input ready when full", 16'h0000, 16'(ddc_ready_out));
    mode = 2'd1;
    repeat (20) cyc(1'b0, 1'b0, 12'h000, 8'h00);
    mode = 2'd3;
    repeat (12) cyc(1'b0, 1'b0, 12'h000, 8'h00);
    cmp_val("words left", 16'h0000, 16'(q.size()));
    cmp_val("output valid when drained", 16'h0000, 16'(cplx_valid_out));
    results;
  end

  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule : tb
`default_nettype wire
